// ---- rtl/sas_map.vh ----
// Register offsets, bit positions, reset values and timing counts of the converter sequencer.
`ifndef SAS_MAP_VH
`define SAS_MAP_VH

`define SAS_RESULT_OFFSET   4'h0
`define SAS_CONTROL_OFFSET  4'h4
`define SAS_MODE_OFFSET     4'h8

`define SAS_IRQ_EN_BIT      7
`define SAS_DONE_BIT        6
`define SAS_TRIGGER_BIT     5
`define SAS_POWER_BIT       4

`define SAS_CONTROL_RESET   8'h40
`define SAS_RESULT_RESET    8'h00
`define SAS_FULL_SCALE      8'hFF

`define SAS_CONV_TIME_NS    70000
`define SAS_CLK_PERIOD_NS   40
`define SAS_CONV_CYCLES     (`SAS_CONV_TIME_NS / `SAS_CLK_PERIOD_NS)
`define SAS_BIT_CYCLES      (`SAS_CONV_CYCLES / 8)

`define SAS_RESP_OKAY       2'b00
`define SAS_RESP_SLVERR     2'b10

`endif

// ---- rtl/sas_sequencer.v ----
// Successive-approximation converter sequencer with an AXI4-Lite register slave.
`include "sas_map.vh"

// Notes on behaviour
// - Each finished conversion lands as an 8-bit value in a readable result register.
// - Input at or above upper reference saturates at full scale, no overflow flag.
// - Input at or below lower reference gives an all-zero result.
// - Result bits are decided from the most significant bit downward.
// - Writing one to the trigger starts a conversion and clears the completion flag.
// - Hardware sets the completion flag when a conversion ends; result then valid.
// - Interrupt request is high while completion flag and interrupt enable are set.
// - Trigger during a running conversion abandons it and starts afresh at once.
// - Trigger bit is write-only and always reads as zero.
// - One conversion per trigger write, then the converter stops.
// - Completion flag clears only on a trigger write, even one that cannot start; writing zero does nothing.
// - Clearing the power bit turns the converter off; no conversion while off.
// - Wait mode keeps converting and wakes the device; stop mode disables the converter.
// - A conversion takes about 70 microseconds at the nominal clock.
// - Control register: enable bit 7, flag bit 6, trigger bit 5, power bit 4; reset 40h.
// - Power bit one switches the converter on, zero switches it off.
module sas_sequencer
(
    input  wire        clk,
    input  wire        sys_rst,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        comp_in,
    input  wire        wait_mode,
    input  wire        stop_mode,
    output reg  [7:0]  dac_code,
    output reg         analog_enable,
    output reg         conv_irq,
    output reg         wake_request
);

    // The bit time comes from the nominal conversion time spread over eight decisions.
    localparam integer BIT_CYCLES_FULL = `SAS_BIT_CYCLES;
    localparam [15:0]  BIT_CYCLES      = BIT_CYCLES_FULL[15:0];
    localparam [3:0]   RESULT_OFFSET   = `SAS_RESULT_OFFSET;
    localparam [3:0]   CTRL_OFFSET     = `SAS_CONTROL_OFFSET;

    localparam [1:0] ST_IDLE   = 2'b00;
    localparam [1:0] ST_SETTLE = 2'b01;
    localparam [1:0] ST_DECIDE = 2'b10;

    reg  [1:0]  state;
    reg  [15:0] cycle_cnt;
    reg  [2:0]  bit_idx;
    reg  [7:0]  trial;
    reg  [7:0]  result_holding_reg;
    reg         conv_irq_enable;
    reg         conv_done;
    reg         converter_power_bit;
    reg         comp_meta;
    reg         comp_sync;
    reg         stop_meta;
    reg         stop_sync;
    reg         wait_meta;
    reg         wait_sync;
    reg  [3:0]  aw_addr;
    reg         aw_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_held;
    reg  [31:0] next_rdata;
    reg  [1:0]  next_rresp;

    wire        write_fire;
    wire        write_ctrl;
    wire        trigger_write;
    wire        conv_enabled;
    wire        ctrl_selected;
    wire        bit_tick;
    wire [7:0]  test_mask;
    wire [7:0]  kept_trial;
    wire [7:0]  next_trial;
    genvar      gi;

    assign ctrl_selected = (aw_addr[3:2] == CTRL_OFFSET[3:2]);
    assign write_fire    = aw_held && w_held && !s_axi_bvalid;
    assign write_ctrl    = write_fire && ctrl_selected && w_strb[0];
    // A trigger written together with the power bit still sees the old power bit, so
    // software must power the converter in an earlier write for the start to take.
    assign trigger_write = write_ctrl && w_data[`SAS_TRIGGER_BIT];
    // Stop mode gates the converter just as the power bit does.
    assign conv_enabled  = converter_power_bit && !stop_sync;

    // The settle counter is the bit-rate divider: bit_tick is a one-cycle enable
    // on the last cycle of each settle period.
    assign bit_tick = (cycle_cnt == BIT_CYCLES - 16'h0001);

    // One decision cell per result bit: the bit under test survives only when the
    // comparator reports the input at or above the trial level, and the next lower
    // bit is then raised as the new trial.
    assign test_mask = 8'h01 << bit_idx;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_bit
            assign kept_trial[gi] = test_mask[gi] ? (trial[gi] & comp_sync) : trial[gi];
        end
    endgenerate
    assign next_trial = kept_trial | (test_mask >> 1);

    // Comparator and mode lines arrive from the analog and clock system, so resynchronise.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
            stop_meta <= 1'b0;
            stop_sync <= 1'b0;
            wait_meta <= 1'b0;
            wait_sync <= 1'b0;
        end
        else
        begin
            comp_meta <= comp_in;
            comp_sync <= comp_meta;
            stop_meta <= stop_mode;
            stop_sync <= stop_meta;
            wait_meta <= wait_mode;
            wait_sync <= wait_meta;
        end
    end

    // Write channel: address and data are latched independently, in either order.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SAS_RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 4'h0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (write_fire)
            begin
                s_axi_bvalid <= 1'b1;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                // Result register is read-only; writing it or an unmapped word is an error.
                if (ctrl_selected)
                    s_axi_bresp <= `SAS_RESP_OKAY;
                else
                    s_axi_bresp <= `SAS_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always @*
    begin
        next_rdata = 32'h0000_0000;
        next_rresp = `SAS_RESP_OKAY;
        // Reserved control bits read as zero, and so does the trigger position.
        case (s_axi_araddr[3:2])
            RESULT_OFFSET[3:2]:
                next_rdata[7:0] = result_holding_reg;
            CTRL_OFFSET[3:2]:
            begin
                next_rdata[`SAS_IRQ_EN_BIT] = conv_irq_enable;
                next_rdata[`SAS_DONE_BIT]   = conv_done;
                next_rdata[`SAS_TRIGGER_BIT] = 1'b0;
                next_rdata[`SAS_POWER_BIT]  = converter_power_bit;
            end
            default:
                next_rresp = `SAS_RESP_SLVERR;
        endcase
    end

    // Read channel answers one cycle after the address is taken.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SAS_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Control bits and the conversion engine share one process so that start and finish
    // on the same edge resolve predictably: a fresh start always wins.
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            conv_irq_enable     <= 1'b0;
            conv_done           <= 1'b1;
            converter_power_bit <= 1'b0;
            state               <= ST_IDLE;
            cycle_cnt           <= 16'h0000;
            bit_idx             <= 3'h7;
            trial               <= 8'h00;
            dac_code            <= 8'h00;
            result_holding_reg  <= `SAS_RESULT_RESET;
            analog_enable       <= 1'b0;
        end
        else
        begin
            if (write_ctrl)
            begin
                conv_irq_enable     <= w_data[`SAS_IRQ_EN_BIT];
                converter_power_bit <= w_data[`SAS_POWER_BIT];
            end
            analog_enable <= conv_enabled;
            if (trigger_write && conv_enabled)
            begin
                conv_done <= 1'b0;
                state     <= ST_SETTLE;
                bit_idx   <= 3'h7;
                trial     <= 8'h80;
                dac_code  <= 8'h80;
                cycle_cnt <= 16'h0000;
            end
            else if (trigger_write)
            begin
                conv_done <= 1'b0;
                state     <= ST_IDLE;
                dac_code  <= 8'h00;
            end
            else if (!conv_enabled)
            begin
                // An abandoned conversion parks the trial level so no stale code remains.
                state    <= ST_IDLE;
                dac_code <= 8'h00;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                        state <= ST_IDLE;
                    ST_SETTLE:
                    begin
                        // Each bit gets an equal share of the conversion time.
                        if (bit_tick)
                        begin
                            cycle_cnt <= 16'h0000;
                            state     <= ST_DECIDE;
                        end
                        else
                            cycle_cnt <= cycle_cnt + 16'h0001;
                    end
                    ST_DECIDE:
                    begin
                        // Comparator high means input is at or above the trial level: keep the bit.
                        // Full-scale and zero inputs fall out naturally as FFh and 00h.
                        if (bit_idx == 3'h0)
                        begin
                            result_holding_reg <= kept_trial;
                            dac_code           <= 8'h00;
                            conv_done          <= 1'b1;
                            state              <= ST_IDLE;
                        end
                        else
                        begin
                            trial    <= next_trial;
                            dac_code <= next_trial;
                            bit_idx  <= bit_idx - 3'h1;
                            state    <= ST_SETTLE;
                        end
                    end
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            conv_irq     <= 1'b0;
            wake_request <= 1'b0;
        end
        else
        begin
            conv_irq     <= conv_done && conv_irq_enable;
            // Completion cannot wake from stop; the stop line gates the wake request directly, since the flag stays set.
            wake_request <= conv_done && conv_irq_enable && wait_sync && !stop_sync;
        end
    end

endmodule

// ---- testbench/sar_adc_sequencer_tb.sv ----
// Self-checking bench for the converter sequencer.
`include "sas_map.vh"
module sar_adc_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] ctl = `SAS_CONTROL_OFFSET;
    localparam logic [3:0] res = `SAS_RESULT_OFFSET;
    localparam logic [1:0] ok = `SAS_RESP_OKAY;
    localparam logic [1:0] er = `SAS_RESP_SLVERR;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        wait_mode = 1'b0;
    logic        stop_mode = 1'b0;
    logic [7:0]  ain_code = 8'h00;
    logic [7:0]  codes [3] = '{8'h00, 8'hff, 8'ha5};
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [7:0]  dac_code;
    wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic        comp_in, analog_enable, conv_irq, wake_request;
    int mismatches = 0;
    int num_checks = 0;
    sas_sequencer u_dut (.*);
    sas_comparator_model u_pin (.clk(clk), .ain_code(ain_code), .dac_code(dac_code),
        .analog_enable(analog_enable), .comp_out(comp_in));
    initial forever #20 clk = ~clk;
    task automatic close_out;
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1 && n < 60);
        s_axi_bready <= 1'b0;
        if (s_axi_bvalid !== 1'b1) begin mismatches++; close_out; end
        check_data({30'h0, s_axi_bresp}, {30'h0, e});
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1 && n < 60);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (s_axi_rvalid !== 1'b1) begin mismatches++; close_out; end
    endtask
    task automatic chk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] x);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        check_data(d, e);
        check_data({30'h0, r}, {30'h0, x});
    endtask
    task automatic wait_done(input int limit);
        logic [31:0] d;
        logic [1:0]  r;
        for (int k = 0; k < limit; k++)
        begin
            rd(ctl, d, r);
            if (d[6] === 1'b1) break;
        end
        if (d[6] !== 1'b1) begin mismatches++; close_out; end
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        mismatches++;
        close_out;
    end
    initial
    begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        chk(ctl, 32'h0000_0040, ok);
        chk(res, 32'h0000_0000, ok);
        chk(4'h8, 32'h0000_0000, er);
        wr(res, 32'h0000_00aa, er);
        wr(ctl, 32'h0000_0010, ok);
        chk(ctl, 32'h0000_0050, ok);
        check_data({31'h0, analog_enable}, 32'h0000_0001);
        for (int i = 0; i < 3; i++)
        begin
            ain_code <= codes[i];
            wr(ctl, 32'h0000_0030, ok);
            chk(ctl, 32'h0000_0010, ok);
            repeat (1650) @(posedge clk);
            chk(ctl, 32'h0000_0010, ok);
            wait_done(40);
            chk(res, {24'h00_0000, codes[i]}, ok);
        end
        wr(ctl, 32'h0000_0010, ok);
        chk(ctl, 32'h0000_0050, ok);
        ain_code <= 8'h3c;
        wr(ctl, 32'h0000_0030, ok);
        repeat (900) @(posedge clk);
        ain_code <= 8'hc3;
        wr(ctl, 32'h0000_0030, ok);
        wait_done(800);
        chk(res, 32'h0000_00c3, ok);
        ain_code <= 8'h11;
        repeat (2000) @(posedge clk);
        check_data({24'h00_0000, dac_code}, 32'h0000_0000);
        chk(res, 32'h0000_00c3, ok);
        wr(ctl, 32'h0000_0090, ok);
        repeat (2) @(posedge clk);
        check_data({31'h0, conv_irq}, 32'h0000_0001);
        wait_mode <= 1'b1;
        repeat (5) @(posedge clk);
        check_data({31'h0, wake_request}, 32'h0000_0001);
        stop_mode <= 1'b1;
        repeat (6) @(posedge clk);
        check_data({31'h0, wake_request}, 32'h0000_0000);
        stop_mode <= 1'b0;
        wait_mode <= 1'b0;
        wr(ctl, 32'h0000_0010, ok);
        repeat (2) @(posedge clk);
        check_data({31'h0, conv_irq}, 32'h0000_0000);
        wr(ctl, 32'h0000_0030, ok);
        repeat (100) @(posedge clk);
        wr(ctl, 32'h0000_0000, ok);
        repeat (2000) @(posedge clk);
        chk(ctl, 32'h0000_0000, ok);
        check_data({31'h0, analog_enable}, 32'h0000_0000);
        check_data({24'h00_0000, dac_code}, 32'h0000_0000);
        close_out;
    end
endmodule

// ---- testbench/sas_comparator_model.sv ----
// Behavioural comparator standing at the single analog input pin.
module sas_comparator_model (
    input wire logic       clk,
    input wire logic [7:0] ain_code,
    input wire logic [7:0] dac_code,
    input wire logic       analog_enable,
    output logic           comp_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Unpowered, the output has no defined level, so it toggles to expose reliance on it.
    always @(posedge clk)
    begin
        if (analog_enable)
            comp_out <= (ain_code >= dac_code);
        else
            comp_out <= ~comp_out;
    end
endmodule

// ---- testbench/sas_monitor.sv ----
// Concurrent checks on the converter sequencer ports.
module sas_monitor (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        stop_mode,
    input wire logic [7:0]  dac_code,
    input wire logic        analog_enable,
    input wire logic        conv_irq,
    input wire logic        wake_request
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    chk_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data wider than a byte");
    chk_msb_first: assert property ($past(dac_code) == 8'h00 && dac_code != 8'h00
        |-> dac_code == 8'h80) else $error("first trial is not the top bit");
    chk_trial_hold: assert property (dac_code != 8'h00 && $changed(dac_code)
        |=> $stable(dac_code) [*8]) else $error("trial level not held");
    chk_idle_off: assert property (!analog_enable [*3] |-> dac_code == 8'h00)
        else $error("trial level while powered off");
    chk_stop_off: assert property (stop_mode [*6] |-> !analog_enable && !wake_request)
        else $error("converter active in stop");
    chk_wake_irq: assert property (wake_request |-> conv_irq)
        else $error("wake without interrupt");
endmodule

bind sas_sequencer sas_monitor u_monitor (.*);
